//--- logic/wdt_top.v
`timescale 1ns/100ps
`include "wdt_defines.vh"

// What this block does
// R1 - In backup, alarm IRQ needs both enables
// R2 - Power-up clears enables; alarm still sets flag
// R3 - Watchdog byte at 7FF7h: multiplier over resolution
// R4 - Resolution 1/16, 1/4, 1, 4 seconds
// R5 - Timeout equals multiplier times resolution
// R6 - Host restarts watchdog by accessing its register
// R7 - Expiry sets flag; interrupt until flag/register access
// R8 - Steering zero: expiry drives interrupt output
// R9 - Steering one: reset pulse 40 to 200 ms
// R10 - After reset pulse clear register and test bit
// R11 - Any watchdog register access restarts full period
// R12 - Register value zero disables the watchdog
// R13 - Power-up clears watchdog register and alarm enables
// R14 - Watchdog interrupt overrides frequency test output
// R15 - Flags access releases output; alarm flag clears after
// R16 - Frequency test toggles output at 512 Hz
// R17 - Sixteenth second every 2048 oscillator cycles
// R18 - Alarm match is one-cycle event, any power
module wdt_top #(
  parameter [22:0] RST_PULSE_CYCLES = `WDT_RST_PULSE_CYCLES
) (
  input  wire        clock,                  // 50 MHz system clock
  input  wire        reset,                  // Power-on reset, synchronous
  input  wire [14:0] address,                // Bus address pins
  input  wire [7:0]  data_in,                // Data pins, input side
  output reg  [7:0]  data_out,               // Data pins, output side
  output reg         data_oe_n,              // Low while driving data pins
  input  wire        chip_enable_n,          // Chip enable pin
  input  wire        output_enable_n,        // Output enable pin
  input  wire        write_enable_n,         // Write enable pin
  input  wire        osc_clock,              // 32.768 kHz oscillator level
  input  wire        osc_running,            // Oscillator is running
  input  wire        on_battery,             // Running from backup battery
  input  wire        power_up_transition,    // Power-up transition in progress
  input  wire        battery_low,            // Battery low flag from monitor
  input  wire        alarm_match,            // One-cycle alarm match event
  input  wire        interrupt_or_test_in,   // Open-drain pin level, unused
  output reg         interrupt_or_test_out,  // Open-drain pin output, always 0
  output reg         interrupt_or_test_oe_n, // Low pulls the pin low
  input  wire        reset_pin_in,           // Open-drain pin level, unused
  output reg         reset_pin_out,          // Open-drain pin output, always 0
  output reg         reset_pin_oe_n          // Low pulls reset pin low
);

  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_RUN   = 3'h2;
  localparam [2:0] ST_PULSE = 3'h4;

  wire [25:0] bus_sync;
  wire        osc_sync;

  wdt_sync #(.WIDTH(26), .INIT(26'h3FFFFFF)) u_bus_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in ({chip_enable_n, output_enable_n, write_enable_n, address, data_in}),
    .sync_out (bus_sync)
  );

  wdt_sync #(.WIDTH(1), .INIT(1'b0)) u_osc_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in (osc_clock),
    .sync_out (osc_sync)
  );

  wire        s_ce_n = bus_sync[25];
  wire        s_oe_n = bus_sync[24];
  wire        s_we_n = bus_sync[23];
  wire [14:0] s_addr = bus_sync[22:8];
  wire [7:0]  s_data = bus_sync[7:0];

  reg  [7:0]  wd_reg;
  reg  [7:0]  ie_reg;
  reg         ft_en;
  reg         wf;
  reg         af;
  reg         irq_wd;
  reg         irq_alarm;
  reg  [2:0]  state;
  reg  [10:0] count;
  reg  [10:0] wd_sub;
  reg  [10:0] presc;
  reg         osc_d;
  reg  [22:0] pulse_cnt;
  reg         active_d;
  reg  [14:0] acc_addr;
  reg         acc_write;
  reg  [7:0]  wr_data;
  reg         reload_d;
  reg  [10:0] unit;
  reg  [7:0]  read_value;

  // Reads and writes are ignored on battery; the bus is locked out then
  wire active    = ~s_ce_n & (~s_oe_n | ~s_we_n) & ~on_battery;
  wire acc_start = active & ~active_d;
  wire acc_end   = ~active & active_d;
  wire wr_end    = acc_end & acc_write;

  wire start_wd    = acc_start & (s_addr == `WDT_ADDR_WATCHDOG);
  wire start_flags = acc_start & (s_addr == `WDT_ADDR_FLAGS);
  wire end_wd      = acc_end & (acc_addr == `WDT_ADDR_WATCHDOG);
  wire end_flags   = acc_end & (acc_addr == `WDT_ADDR_FLAGS);
  wire restart     = start_wd | end_wd;                       // see R6, see R11

  wire osc_rise  = osc_sync & ~osc_d;
  wire sixteenth = osc_rise & (wd_sub == `WDT_OSC_SIXTEENTH_LAST); // see R17

  wire [4:0] mult   = wd_reg[`WDT_WD_MULT_MSB:`WDT_WD_MULT_LSB];  // see R3
  wire [1:0] res    = wd_reg[`WDT_WD_RES_MSB:`WDT_WD_RES_LSB];
  wire [10:0] period = {6'h00, mult} * unit;                  // see R5
  wire wd_zero = (wd_reg == `WDT_RESET_BYTE);
  wire steer   = wd_reg[`WDT_WD_STEER_BIT];
  wire expire  = (state == ST_RUN) & ~restart & ~reload_d & sixteenth & (count <= 11'h001);
  wire pulse_done = (state == ST_PULSE) & (pulse_cnt == 23'h000000);

  wire ae  = ie_reg[`WDT_IE_AE_BIT];
  wire abe = ie_reg[`WDT_IE_ABE_BIT];
  wire alarm_irq_set = alarm_match & ae & (~on_battery | abe);  // see R1, see R18

  // Square wave only when watchdog cannot claim the pin
  wire ft_mode = osc_running & ft_en & ~ae & (steer | wd_zero); // see R14, see R16
  wire irq_low = irq_wd | irq_alarm | (ft_mode & ~presc[`WDT_FT_PRESC_BIT]);

  always @* begin
    case (res)                                                 // see R4
      `WDT_RES_SIXTEENTH: unit = `WDT_UNITS_SIXTEENTH;
      `WDT_RES_QUARTER:   unit = `WDT_UNITS_QUARTER;
      `WDT_RES_ONE_SEC:   unit = `WDT_UNITS_ONE_SEC;
      default:            unit = `WDT_UNITS_FOUR_SEC;
    endcase
  end

  always @* begin
    case (s_addr)
      `WDT_ADDR_FLAGS:      read_value = {wf, af, 1'b0, battery_low, 4'h0};
      `WDT_ADDR_IRQ_ENABLE: read_value = ie_reg;
      `WDT_ADDR_WATCHDOG:   read_value = wd_reg;
      `WDT_ADDR_FREQ_TEST:  read_value = {1'b0, ft_en, 6'h00};
      default:              read_value = 8'h00;
    endcase
  end

  wire hit = (s_addr == `WDT_ADDR_FLAGS) | (s_addr == `WDT_ADDR_IRQ_ENABLE) |
             (s_addr == `WDT_ADDR_WATCHDOG) | (s_addr == `WDT_ADDR_FREQ_TEST);

  // Bus access tracking and read data
  always @(posedge clock) begin
    if (reset) begin
      active_d  <= 1'b0;
      acc_addr  <= 15'h0000;
      acc_write <= 1'b0;
      wr_data   <= 8'h00;
      data_out  <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      active_d <= active;
      if (acc_start) begin
        acc_addr  <= s_addr;
        acc_write <= ~s_we_n;
        data_out  <= read_value;
        data_oe_n <= ~(hit & s_we_n);
      end else if (acc_end) begin
        data_oe_n <= 1'b1;
      end
      // Data is taken while the strobe is still active, not on its release
      if (active & ~s_we_n)
        wr_data <= s_data;
    end
  end

  // Control registers
  always @(posedge clock) begin
    if (reset) begin
      wd_reg <= `WDT_RESET_BYTE;                               // see R13
      ie_reg <= `WDT_RESET_BYTE;
      ft_en  <= 1'b0;
    end else begin
      if (wr_end & (acc_addr == `WDT_ADDR_WATCHDOG))
        wd_reg <= wr_data;
      if (wr_end & (acc_addr == `WDT_ADDR_IRQ_ENABLE))
        ie_reg <= wr_data;
      if (wr_end & (acc_addr == `WDT_ADDR_FREQ_TEST))
        ft_en <= wr_data[`WDT_FT_BIT];
      if (power_up_transition) begin
        ie_reg[`WDT_IE_AE_BIT]  <= 1'b0;                       // see R2, see R13
        ie_reg[`WDT_IE_ABE_BIT] <= 1'b0;
      end
      if (pulse_done) begin
        wd_reg <= `WDT_RESET_BYTE;                             // see R10
        ft_en  <= 1'b0;
      end
    end
  end

  // Flags and interrupt sources; a set in the same cycle beats a clear
  always @(posedge clock) begin
    if (reset) begin
      wf        <= 1'b0;
      af        <= 1'b0;
      irq_wd    <= 1'b0;
      irq_alarm <= 1'b0;
    end else begin
      if (expire)
        wf <= 1'b1;                                            // see R7
      else if (end_flags & ~acc_write)
        wf <= 1'b0;
      if (alarm_match)
        af <= 1'b1;                                            // see R2, see R18
      else if (end_flags)
        af <= 1'b0;                                            // see R15
      if (expire & ~steer)
        irq_wd <= 1'b1;                                        // see R8
      else if (start_flags | start_wd)
        irq_wd <= 1'b0;                                        // see R7
      if (alarm_irq_set)
        irq_alarm <= 1'b1;
      else if (start_flags)
        irq_alarm <= 1'b0;                                     // see R15
    end
  end

  // Watchdog countdown in sixteenths of a second
  always @(posedge clock) begin
    if (reset) begin
      state     <= ST_IDLE;
      count     <= 11'h000;
      wd_sub    <= 11'h000;
      pulse_cnt <= 23'h000000;
      reload_d  <= 1'b0;
      osc_d     <= 1'b0;
      presc     <= 11'h000;
    end else begin
      osc_d    <= osc_sync;
      reload_d <= restart;
      if (osc_rise)
        presc <= presc + 11'h001;
      if (osc_rise)
        wd_sub <= wd_sub + 11'h001;
      case (state)
        ST_IDLE: begin
          if (~wd_zero) begin
            state  <= ST_RUN;
            count  <= period;
            wd_sub <= 11'h000;
          end
        end
        ST_RUN: begin
          if (wd_zero) begin
            state <= ST_IDLE;                                  // see R12
          end else if (restart | reload_d) begin
            count  <= period;                                  // see R11
            wd_sub <= 11'h000;
          end else if (expire) begin
            count <= period;
            if (steer) begin
              state     <= ST_PULSE;                           // see R9
              pulse_cnt <= RST_PULSE_CYCLES - 23'h000001;
            end
          end else if (sixteenth) begin
            count <= count - 11'h001;
          end
        end
        ST_PULSE: begin
          if (pulse_done)
            state <= ST_IDLE;
          else
            pulse_cnt <= pulse_cnt - 23'h000001;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Open-drain pins
  always @(posedge clock) begin
    if (reset) begin
      interrupt_or_test_out  <= 1'b0;
      interrupt_or_test_oe_n <= 1'b1;
      reset_pin_out          <= 1'b0;
      reset_pin_oe_n         <= 1'b1;
    end else begin
      interrupt_or_test_out  <= 1'b0;
      interrupt_or_test_oe_n <= ~irq_low;                      // see R8, see R14
      reset_pin_out          <= 1'b0;
      reset_pin_oe_n         <= ~(state == ST_PULSE);          // see R9
    end
  end

endmodule // wdt_top

//--- logic/wdt_defines.vh
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// Register byte addresses on the bytewide bus
`define WDT_ADDR_FLAGS      15'h7FF0
`define WDT_ADDR_IRQ_ENABLE 15'h7FF6
`define WDT_ADDR_WATCHDOG   15'h7FF7
`define WDT_ADDR_FREQ_TEST  15'h7FFC

// Field positions
`define WDT_FLAGS_WF_BIT    7
`define WDT_FLAGS_AF_BIT    6
`define WDT_FLAGS_BLF_BIT   4
`define WDT_IE_AE_BIT       7
`define WDT_IE_ABE_BIT      5
`define WDT_FT_BIT          6
`define WDT_WD_STEER_BIT    7
`define WDT_WD_MULT_MSB     6
`define WDT_WD_MULT_LSB     2
`define WDT_WD_RES_MSB      1
`define WDT_WD_RES_LSB      0

// Reset values
`define WDT_RESET_BYTE      8'h00

// Resolution codes and their length in sixteenths of a second
`define WDT_RES_SIXTEENTH   2'h0
`define WDT_RES_QUARTER     2'h1
`define WDT_RES_ONE_SEC     2'h2
`define WDT_RES_FOUR_SEC    2'h3
`define WDT_UNITS_SIXTEENTH 11'h001
`define WDT_UNITS_QUARTER   11'h004
`define WDT_UNITS_ONE_SEC   11'h010
`define WDT_UNITS_FOUR_SEC  11'h040

// Oscillator division: 2048 oscillator cycles make one sixteenth second
`define WDT_OSC_SIXTEENTH_LAST 11'h7FF
// 32768 Hz / 64 = 512 Hz, so the square wave is prescaler bit 5
`define WDT_FT_PRESC_BIT    5

// Timing: 100 ms reset pulse at 50 MHz, inside the 40 to 200 ms window
`define WDT_RST_PULSE_CYCLES 23'h4C4B40

`endif

//--- logic/wdt_sync.v
`timescale 1ns/100ps
// Two-flop synchroniser for pins from outside the clock domain
module wdt_sync #(
  parameter            WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input  wire             clock,   // System clock
  input  wire             reset,   // Synchronous, active high
  input  wire [WIDTH-1:0] async_in, // Raw pin levels
  output reg  [WIDTH-1:0] sync_out  // Second stage
);

  reg [WIDTH-1:0] stage1;

  always @(posedge clock) begin
    if (reset) begin
      stage1   <= INIT;
      sync_out <= INIT;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // wdt_sync

//--- test/wdt_chk.sv
`timescale 1ns/100ps
module wdt_chk #(
  parameter [22:0] RST_PULSE_CYCLES = 23'h000014
) (
  input wire        clock,                  // Clock
  input wire        reset,                  // Reset
  input wire [14:0] address,                // Address
  input wire [7:0]  data_out,               // Read data
  input wire        data_oe_n,              // Data driven
  input wire        chip_enable_n,          // Chip enable
  input wire        output_enable_n,        // Output enable
  input wire        write_enable_n,         // Write enable
  input wire        osc_running,            // Oscillator on
  input wire        on_battery,             // Backup mode
  input wire        power_up_transition,    // Power-up
  input wire        alarm_match,            // Alarm event
  input wire        interrupt_or_test_out,  // Pin value
  input wire        interrupt_or_test_oe_n, // Pin pulled
  input wire        reset_pin_out,          // Pin value
  input wire        reset_pin_oe_n          // Pin pulled
);
  reg [22:0] low_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Length of the current reset pulse
  always @(posedge clock)
    low_cnt <= reset_pin_oe_n ? 23'h000000 : low_cnt + 23'h000001;
  sequence s_acc(a);
    (!chip_enable_n && !(output_enable_n && write_enable_n) && !on_battery && address == a)[*3];
  endsequence
  // Without the oscillator neither watchdog nor square wave can pull the pin
  sequence s_pwrup_alarm;
    power_up_transition[*2] ##0 (alarm_match && !osc_running && interrupt_or_test_oe_n);
  endsequence
  AST_DRV_MAPPED: assert property (!data_oe_n |->
    $past(address, 3) inside {15'h7FF0, 15'h7FF6, 15'h7FF7, 15'h7FFC}) else $error("unmapped read");
  AST_RST_IDLE: assert property ($fell(reset) |->
    data_oe_n && interrupt_or_test_oe_n && reset_pin_oe_n) else $error("busy after reset");
  AST_PULSE_LEN: assert property ($rose(reset_pin_oe_n) |->
    low_cnt == RST_PULSE_CYCLES) else $error("reset pulse length");
  AST_FLAGS_REL: assert property (s_acc(15'h7FF0) |->
    ##[1:3] interrupt_or_test_oe_n) else $error("flags access kept pin low");
  AST_WD_REL: assert property (s_acc(15'h7FF7) |->
    ##[1:3] interrupt_or_test_oe_n) else $error("timer access kept pin low");
  AST_PWRUP: assert property (s_pwrup_alarm |=>
    interrupt_or_test_oe_n[*3]) else $error("alarm pulled pin in power-up");
  AST_FLAGS_BITS: assert property (!data_oe_n && $past(address, 3) == 15'h7FF0 |->
    data_out[5] == 1'b0 && data_out[3:0] == 4'h0) else $error("flags zero bits set");
  AST_OD_ZERO: assert property (!interrupt_or_test_oe_n || !reset_pin_oe_n |->
    !interrupt_or_test_out && !reset_pin_out) else $error("open drain drove high");
endmodule // wdt_chk
bind wdt_top wdt_chk #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) u_chk (.*);

//--- test/wdt_host.sv
`timescale 1ns/100ps
module wdt_host (
  input  wire        clock,     // Clock
  input  wire [7:0]  data_out,  // Device data
  input  wire        data_oe_n, // Device drives
  output reg  [14:0] address,   // Address pins
  output wire [7:0]  data_in,   // Pin level
  output reg         ce_n,      // Chip enable
  output reg         oe_n,      // Output enable
  output reg         we_n       // Write enable
);
  reg [7:0] wr_byte;
  reg       drive;
  // Floating pins show inverted data so stale values never match
  assign data_in = drive ? wr_byte : (!data_oe_n ? data_out : ~wr_byte);
  initial begin
    address = 15'h0000;
    wr_byte = 8'h00;
    drive = 1'b0;
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
  end
  // Timer register accesses double as restarts
  task automatic access(input bit wr, input [14:0] a, input [7:0] d, output [8:0] q);
    @(negedge clock);
    address = a;
    wr_byte = d;
    drive = wr;
    ce_n = 1'b0;
    oe_n = wr;
    we_n = !wr;
    repeat (5) @(negedge clock);
    @(posedge clock);
    q = {data_oe_n, data_oe_n ? 8'h00 : data_out};
    @(negedge clock);
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    drive = 1'b0;
    repeat (3) @(negedge clock);
  endtask
endmodule // wdt_host

//--- test/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam SIXT = 4096;
  reg         clock, reset, osc_clock, osc_en, osc_running, on_battery, power_up_transition;
  reg         battery_low, alarm_match, p, m_wf, m_af;
  reg  [7:0]  m_wd, m_ie, m_ft, v;
  reg  [8:0]  q;
  wire [14:0] address;
  wire [7:0]  data_in, data_out;
  wire        data_oe_n, ce_n, oe_n, we_n, irq_out, irq_oe_n, rst_out, rst_oe_n;
  wire        irq_pin = irq_oe_n | irq_out;
  wire        rst_pin = rst_oe_n | rst_out;
  integer     bad_count, samples_checked, n, k, falls;
  wdt_top #(.RST_PULSE_CYCLES(23'h000014)) u_dut (.clock(clock), .reset(reset),
    .address(address), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .chip_enable_n(ce_n), .output_enable_n(oe_n), .write_enable_n(we_n),
    .osc_clock(osc_clock), .osc_running(osc_running), .on_battery(on_battery),
    .power_up_transition(power_up_transition), .battery_low(battery_low),
    .alarm_match(alarm_match), .interrupt_or_test_in(irq_pin), .interrupt_or_test_out(irq_out),
    .interrupt_or_test_oe_n(irq_oe_n), .reset_pin_in(rst_pin), .reset_pin_out(rst_out),
    .reset_pin_oe_n(rst_oe_n));
  wdt_host u_host (.clock(clock), .data_out(data_out), .data_oe_n(data_oe_n),
    .address(address), .data_in(data_in), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
  always #10 clock = ~clock;
  always @(negedge clock) if (osc_en) osc_clock <= ~osc_clock;
  function [8:0] expect_rd(input [14:0] a);
    case (a)
      15'h7FF0: expect_rd = {1'b0, m_wf, m_af, 1'b0, battery_low, 4'h0};
      15'h7FF6: expect_rd = {1'b0, m_ie};
      15'h7FF7: expect_rd = {1'b0, m_wd};
      15'h7FFC: expect_rd = {1'b0, m_ft};
      default:  expect_rd = 9'h100;
    endcase
  endfunction
  task chk_rd(input [8:0] got, input [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task chk_pin(input got, input exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: level %b expected %b", $time, got, exp);
    end
  endtask
  task rd(input [14:0] a);
    u_host.access(1'b0, a, 8'h00, q);
    chk_rd(q, expect_rd(a));
    if (a == 15'h7FF0) {m_wf, m_af} = 2'b00;
  endtask
  task wr(input [14:0] a, input [7:0] d);
    u_host.access(1'b1, a, d, q);
    if (a == 15'h7FF0) m_af = 1'b0;
    if (a == 15'h7FF6) m_ie = d;
    if (a == 15'h7FF7) m_wd = d;
    if (a == 15'h7FFC) m_ft = d & 8'h40;
  endtask
  task wait_low(input integer lim, input bit which);
    n = 0;
    while ((which ? rst_pin : irq_pin) && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask
  task count_falls(input integer c);
    repeat (c) begin
      p = irq_pin;
      @(negedge clock);
      if (p && !irq_pin) falls++;
    end
  endtask
  task expire(input integer t);
    repeat (t - 150) @(negedge clock);
    chk_pin(irq_pin, 1'b1);
    wait_low(300, 1'b0);
    chk_pin(irq_pin, 1'b0);
    m_wf = 1'b1;
  endtask
  task pulse;
    @(negedge clock);
    alarm_match = 1'b1;
    @(negedge clock);
    alarm_match = 1'b0;
    repeat (4) @(negedge clock);
    m_af = 1'b1;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #1800000;
    bad_count++;
    $display("wrong value at %0t: run hung", $time);
    give_verdict;
  end
  initial begin
    {clock, osc_clock, on_battery, power_up_transition, alarm_match, battery_low} = 6'h00;
    {reset, osc_en, osc_running} = 3'h7;
    {m_wd, m_ie, m_ft, m_wf, m_af} = 26'h0000000;
    bad_count = 0;
    samples_checked = 0;
    v = $urandom(82);
    repeat (10) @(negedge clock);
    reset = 1'b0;
    battery_low = $urandom % 2;
    repeat (3) @(negedge clock);
    rd(15'h7FF7);
    rd(15'h7FF6);
    rd(15'h7FF1);
    rd(15'h7FF0);
    $display("test reset values done");
    for (k = 0; k < 4; k++) begin
      v = {1'b0, (k < 2) ? 5'h02 : 5'h01 + 5'($urandom % 31), 2'(k)};
      wr(15'h7FF7, v);
      rd(15'h7FF7);
      if (k < 2) begin
        expire(2 * (k ? 4 : 1) * SIXT);
        rd(15'h7FF0);
        chk_pin(irq_pin, 1'b1);
      end
    end
    wr(15'h7FF7, 8'h00);
    repeat (9000) @(negedge clock);
    chk_pin(irq_pin, 1'b1);
    $display("test timeout periods done");
    wr(15'h7FF7, 8'h04);
    // Timer steered to the pin, so the square wave must stay off
    wr(15'h7FFC, 8'h40);
    falls = 0;
    repeat (4) begin
      count_falls(3000);
      rd(15'h7FF7);
    end
    chk_pin(irq_pin, 1'b1);
    chk_pin(falls == 0, 1'b1);
    expire(SIXT);
    rd(15'h7FF0);
    $display("test restart done");
    wr(15'h7FF7, 8'h84);
    wr(15'h7FFC, 8'h40);
    falls = 0;
    count_falls(1280);
    chk_pin(falls >= 9 && falls <= 11, 1'b1);
    wait_low(4096, 1'b1);
    chk_pin(rst_pin, 1'b0);
    n = 0;
    while (!rst_pin && n < 100) begin
      n++;
      @(negedge clock);
    end
    chk_pin(n == 20, 1'b1);
    {m_wd, m_ft, m_wf} = 17'h00001;
    rd(15'h7FF7);
    rd(15'h7FFC);
    rd(15'h7FF0);
    $display("test reset steering done");
    {osc_en, osc_running} = 2'b00;
    wr(15'h7FF6, 8'h80);
    pulse;
    chk_pin(irq_pin, 1'b0);
    rd(15'h7FF0);
    chk_pin(irq_pin, 1'b1);
    on_battery = 1'b1;
    pulse;
    chk_pin(irq_pin, 1'b1);
    on_battery = 1'b0;
    rd(15'h7FF0);
    wr(15'h7FF6, 8'hA0);
    on_battery = 1'b1;
    pulse;
    chk_pin(irq_pin, 1'b0);
    on_battery = 1'b0;
    rd(15'h7FF0);
    power_up_transition = 1'b1;
    repeat (2) @(negedge clock);
    pulse;
    chk_pin(irq_pin, 1'b1);
    power_up_transition = 1'b0;
    m_ie = 8'h00;
    rd(15'h7FF6);
    rd(15'h7FF0);
    $display("test alarm done");
    give_verdict;
  end
endmodule // testbench
